// ### hw/gim_defines.svh
`ifndef GIM_DEFINES_SVH
`define GIM_DEFINES_SVH

`define GIM_OFF_LINE_EN    32'hfffff400
`define GIM_OFF_LINE_DIS   32'hfffff404
`define GIM_OFF_OUT_EN     32'hfffff410
`define GIM_OFF_OUT_DIS    32'hfffff414
`define GIM_OFF_FILT_EN    32'hfffff420
`define GIM_OFF_FILT_DIS   32'hfffff424
`define GIM_OFF_MDRV_EN    32'hfffff450
`define GIM_OFF_MDRV_DIS   32'hfffff454
`define GIM_OFF_PUP_DIS    32'hfffff460
`define GIM_OFF_PUP_EN     32'hfffff464
`define GIM_OFF_PSEL1      32'hfffff470
`define GIM_OFF_PSEL2      32'hfffff474
`define GIM_OFF_PDN_DIS    32'hfffff490
`define GIM_OFF_PDN_STATE  32'hfffff498
`define GIM_OFF_OWR_EN     32'hfffff4a0
`define GIM_OFF_OWR_DIS    32'hfffff4a4
`define GIM_OFF_OWR_STATE  32'hfffff4a8
`define GIM_OFF_AIM_EN     32'hfffff4b0
`define GIM_OFF_AIM_DIS    32'hfffff4b4
`define GIM_OFF_AIM_MASK   32'hfffff4b8
`define GIM_OFF_EDGE_SEL   32'hfffff4c0
`define GIM_OFF_LEVEL_SEL  32'hfffff4c4
`define GIM_OFF_EL_STATE   32'hfffff4c8
`define GIM_OFF_FALL_SEL   32'hfffff4d0
`define GIM_OFF_RISE_SEL   32'hfffff4d4
`define GIM_OFF_POL_STATE  32'hfffff4d8
`define GIM_OFF_LOCK_STATE 32'hfffff4e0
`define GIM_OFF_GUARD_MODE 32'hfffff4e4
`define GIM_OFF_GUARD_VIOL 32'hfffff4e8

`define GIM_GUARD_KEY      24'h50494f
`define GIM_KEY_MSB        31
`define GIM_KEY_LSB        8
`define GIM_EN_BIT         0
`define GIM_VFLAG_BIT      0
`define GIM_VSRC_MSB       23
`define GIM_VSRC_LSB       8
`define GIM_RST_WORD       32'h00000000
`define GIM_RST_SRC        16'h0000

`endif

// ### hw/gim_pkg.sv
package gim_pkg;
  typedef logic [31:0] gim_word_type;
  typedef logic [15:0] gim_src_type;
endpackage

// ### hw/gim_irq_mode_guard.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "gim_defines.svh"

// How it works
// - Output-write status shows lines that data writes drive
// - Enable bit selects edge/level/polarity interrupt source
// - Disable bit returns line to both-edge detection
// - Mask reads 1 when additional mode active
// - Edge select sets line to edge type
// - Level select sets line to level type
// - Edge/level status reads 0 edge, 1 level
// - Fall/low select picks falling or low
// - Rise/high select picks rising or high
// - Polarity status reads 0 fall/low, 1 rise/high
// - Lock status shows locked lines
// - Guard enables only with correct key
// - Guard disables only with correct key
// - Guard blocks writes to protected registers
// - Wrong key ignored; key reads zero
// - Violation flag and source, cleared on read
module gim_irq_mode_guard (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [31:0]         regAddr,
  input  wire logic [31:0]         regWrData,
  input  wire logic                regWrStb,
  input  wire logic                regRdStb,
  output gim_pkg::gim_word_type    regRdData,
  input  wire logic [31:0]         lineIn,
  input  wire logic [31:0]         lineLocked,
  output gim_pkg::gim_word_type    outWriteGate,
  output gim_pkg::gim_word_type    irqSource,
  output logic                     guardEnable,
  output logic                     guardBlock
);

  gim_pkg::gim_word_type owsr_ff;
  gim_pkg::gim_word_type nxt_owsr;
  gim_pkg::gim_word_type aim_ff;
  gim_pkg::gim_word_type nxt_aim;
  gim_pkg::gim_word_type elsr_ff;
  gim_pkg::gim_word_type nxt_elsr;
  gim_pkg::gim_word_type pol_ff;
  gim_pkg::gim_word_type nxt_pol;
  logic                  guard_enable_ff;
  logic                  nxt_guard_enable;
  logic                  vflag_ff;
  logic                  nxt_vflag;
  gim_pkg::gim_src_type  vsrc_ff;
  gim_pkg::gim_src_type  nxt_vsrc;
  gim_pkg::gim_word_type rd_ff;
  gim_pkg::gim_word_type nxt_rd;
  logic                  isProt;

  gim_pkg::gim_word_type sync1_ff;
  gim_pkg::gim_word_type sync2_ff;
  gim_pkg::gim_word_type sync3_ff;
  gim_pkg::gim_word_type stable_ff;
  gim_pkg::gim_word_type prev_ff;
  gim_pkg::gim_word_type nxt_stable;
  gim_pkg::gim_word_type irq_ff;
  gim_pkg::gim_word_type nxt_irq;

  // Decode of the registers that the guard covers
  always_comb begin
    case (regAddr)
      `GIM_OFF_LINE_EN, `GIM_OFF_LINE_DIS,
      `GIM_OFF_OUT_EN, `GIM_OFF_OUT_DIS,
      `GIM_OFF_FILT_EN, `GIM_OFF_FILT_DIS,
      `GIM_OFF_MDRV_EN, `GIM_OFF_MDRV_DIS,
      `GIM_OFF_PUP_DIS, `GIM_OFF_PUP_EN,
      `GIM_OFF_PSEL1, `GIM_OFF_PSEL2,
      `GIM_OFF_OWR_EN, `GIM_OFF_OWR_DIS,
      `GIM_OFF_PDN_DIS, `GIM_OFF_PDN_STATE: isProt = 1'b1;
      default: isProt = 1'b0;
    endcase
  end

  // Neighbouring blocks use this to drop the write in the same cycle
  assign guardBlock  = regWrStb & guard_enable_ff & isProt;
  assign guardEnable = guard_enable_ff;

  // Register file next state
  always_comb begin
    nxt_owsr  = owsr_ff;
    nxt_aim   = aim_ff;
    nxt_elsr  = elsr_ff;
    nxt_pol   = pol_ff;
    nxt_guard_enable  = guard_enable_ff;
    nxt_vflag = vflag_ff;
    nxt_vsrc  = vsrc_ff;
    nxt_rd    = `GIM_RST_WORD;
    // Clear first so a violation in the same cycle still lands
    if (regRdStb && regAddr == `GIM_OFF_GUARD_VIOL) begin
      nxt_vflag = 1'b0;
      nxt_vsrc  = `GIM_RST_SRC;
    end
    if (guardBlock) begin
      nxt_vflag = 1'b1;
      nxt_vsrc  = regAddr[15:0];
    end else if (regWrStb) begin
      case (regAddr)
        `GIM_OFF_OWR_EN:    nxt_owsr = owsr_ff | regWrData;
        `GIM_OFF_OWR_DIS:   nxt_owsr = owsr_ff & ~regWrData;
        `GIM_OFF_AIM_EN:    nxt_aim  = aim_ff | regWrData;
        `GIM_OFF_AIM_DIS:   nxt_aim  = aim_ff & ~regWrData;
        `GIM_OFF_EDGE_SEL:  nxt_elsr = elsr_ff & ~regWrData;
        `GIM_OFF_LEVEL_SEL: nxt_elsr = elsr_ff | regWrData;
        `GIM_OFF_FALL_SEL:  nxt_pol  = pol_ff & ~regWrData;
        `GIM_OFF_RISE_SEL:  nxt_pol  = pol_ff | regWrData;
        `GIM_OFF_GUARD_MODE: begin
          // A wrong key leaves the enable alone
          if (regWrData[`GIM_KEY_MSB:`GIM_KEY_LSB] == `GIM_GUARD_KEY) begin
            nxt_guard_enable = regWrData[`GIM_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (regRdStb) begin
      case (regAddr)
        `GIM_OFF_OWR_STATE:  nxt_rd = owsr_ff;
        `GIM_OFF_AIM_MASK:   nxt_rd = aim_ff;
        `GIM_OFF_EL_STATE:   nxt_rd = elsr_ff;
        `GIM_OFF_POL_STATE:  nxt_rd = pol_ff;
        `GIM_OFF_LOCK_STATE: nxt_rd = lineLocked;
        `GIM_OFF_GUARD_MODE: begin
          nxt_rd = `GIM_RST_WORD;
          nxt_rd[`GIM_EN_BIT] = guard_enable_ff;
        end
        `GIM_OFF_GUARD_VIOL: begin
          nxt_rd = `GIM_RST_WORD;
          nxt_rd[`GIM_VFLAG_BIT] = vflag_ff;
          nxt_rd[`GIM_VSRC_MSB:`GIM_VSRC_LSB] = vsrc_ff;
        end
        default: nxt_rd = `GIM_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      owsr_ff  <= `GIM_RST_WORD;
      aim_ff   <= `GIM_RST_WORD;
      elsr_ff  <= `GIM_RST_WORD;
      pol_ff   <= `GIM_RST_WORD;
      guard_enable_ff  <= 1'b0;
      vflag_ff <= 1'b0;
      vsrc_ff  <= `GIM_RST_SRC;
      rd_ff    <= `GIM_RST_WORD;
    end else begin
      owsr_ff  <= nxt_owsr;
      aim_ff   <= nxt_aim;
      elsr_ff  <= nxt_elsr;
      pol_ff   <= nxt_pol;
      guard_enable_ff  <= nxt_guard_enable;
      vflag_ff <= nxt_vflag;
      vsrc_ff  <= nxt_vsrc;
      rd_ff    <= nxt_rd;
    end
  end

  assign regRdData    = rd_ff;
  assign outWriteGate = owsr_ff;
  assign irqSource    = irq_ff;

  // Pin inputs: a change counts once stages two and three agree
  always_comb begin
    nxt_stable = (sync2_ff ~^ sync3_ff) & sync3_ff |
                 (sync2_ff ^ sync3_ff) & stable_ff;
  end

  // Per-line source selection
  generate
    for (genvar i = 0; i < 32; i++) begin : g_line
      always_comb begin
        if (!aim_ff[i]) begin
          nxt_irq[i] = stable_ff[i] ^ prev_ff[i];
        end else if (elsr_ff[i]) begin
          nxt_irq[i] = ~(stable_ff[i] ^ pol_ff[i]);
        end else if (pol_ff[i]) begin
          nxt_irq[i] = stable_ff[i] & ~prev_ff[i];
        end else begin
          nxt_irq[i] = ~stable_ff[i] & prev_ff[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff  <= `GIM_RST_WORD;
      sync2_ff  <= `GIM_RST_WORD;
      sync3_ff  <= `GIM_RST_WORD;
      stable_ff <= `GIM_RST_WORD;
      prev_ff   <= `GIM_RST_WORD;
      irq_ff    <= `GIM_RST_WORD;
    end else begin
      sync1_ff  <= lineIn;
      sync2_ff  <= sync1_ff;
      sync3_ff  <= sync2_ff;
      stable_ff <= nxt_stable;
      prev_ff   <= stable_ff;
      irq_ff    <= nxt_irq;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_aimSet;
    regWrStb && regAddr == `GIM_OFF_AIM_EN && !guard_enable_ff
      |=> (aim_ff & $past(regWrData)) == $past(regWrData);
  endproperty
  a_aimSet: assert property (p_aimSet)
    else $error("aim enable did not set bits");

  property p_aimClr;
    regWrStb && regAddr == `GIM_OFF_AIM_DIS
      |=> (aim_ff & $past(regWrData)) == 32'h00000000
          && (aim_ff | $past(regWrData)) == ($past(aim_ff) | $past(regWrData));
  endproperty
  a_aimClr: assert property (p_aimClr)
    else $error("aim disable wrong result");

  property p_levelRd;
    regWrStb && regAddr == `GIM_OFF_LEVEL_SEL ##1
      regRdStb && regAddr == `GIM_OFF_EL_STATE
      |=> (regRdData & $past(regWrData, 2)) == $past(regWrData, 2);
  endproperty
  a_levelRd: assert property (p_levelRd)
    else $error("level select not visible in status");

  property p_polRd;
    regRdStb && regAddr == `GIM_OFF_POL_STATE |=> regRdData == $past(pol_ff);
  endproperty
  a_polRd: assert property (p_polRd)
    else $error("polarity status read mismatch");

  property p_badKey;
    regWrStb && regAddr == `GIM_OFF_GUARD_MODE
      && regWrData[31:8] != `GIM_GUARD_KEY |=> $stable(guard_enable_ff);
  endproperty
  a_badKey: assert property (p_badKey)
    else $error("wrong key changed guard enable");

  property p_goodKey;
    regWrStb && regAddr == `GIM_OFF_GUARD_MODE
      && regWrData[31:8] == `GIM_GUARD_KEY
      |=> guard_enable_ff == $past(regWrData[0]);
  endproperty
  a_goodKey: assert property (p_goodKey)
    else $error("correct key did not load guard enable");

  property p_guarded;
    guard_enable_ff && regWrStb && regAddr == `GIM_OFF_OWR_EN
      |=> ($stable(owsr_ff) && vflag_ff
          && vsrc_ff == 16'hf4a0) [*2];
  endproperty
  a_guarded: assert property (p_guarded)
    else $error("protected write not blocked");

  property p_violClr;
    vflag_ff && regRdStb && regAddr == `GIM_OFF_GUARD_VIOL
      |=> regRdData[0] && !vflag_ff && vsrc_ff == 16'h0000;
  endproperty
  a_violClr: assert property (p_violClr)
    else $error("violation not reported then cleared");

  property p_highLevel;
    aim_ff[0] && elsr_ff[0] && pol_ff[0] && stable_ff[0]
      |=> irqSource[0];
  endproperty
  a_highLevel: assert property (p_highLevel)
    else $error("high level source missing");

  property p_bothEdge;
    !aim_ff[0] && $rose(stable_ff[0]) |=> irqSource[0] ##1 !irqSource[0]
      || stable_ff[0] != prev_ff[0];
  endproperty
  a_bothEdge: assert property (p_bothEdge)
    else $error("both-edge source wrong");

  property p_edgeSel;
    regWrStb && regAddr == `GIM_OFF_EDGE_SEL
      |=> (elsr_ff & $past(regWrData)) == 32'h00000000;
  endproperty
  a_edgeSel: assert property (p_edgeSel)
    else $error("edge select did not clear type bits");

  property p_levelSet;
    regWrStb && regAddr == `GIM_OFF_LEVEL_SEL
      |=> (elsr_ff & $past(regWrData)) == $past(regWrData);
  endproperty
  a_levelSet: assert property (p_levelSet)
    else $error("level select did not set type bits");

  property p_fallSel;
    regWrStb && regAddr == `GIM_OFF_FALL_SEL
      |=> (pol_ff & $past(regWrData)) == 32'h00000000;
  endproperty
  a_fallSel: assert property (p_fallSel)
    else $error("fall select did not clear polarity bits");

  property p_riseSel;
    regWrStb && regAddr == `GIM_OFF_RISE_SEL
      |=> (pol_ff & $past(regWrData)) == $past(regWrData);
  endproperty
  a_riseSel: assert property (p_riseSel)
    else $error("rise select did not set polarity bits");

  property p_elRd;
    regRdStb && regAddr == `GIM_OFF_EL_STATE
      |=> regRdData == $past(elsr_ff);
  endproperty
  a_elRd: assert property (p_elRd)
    else $error("edge/level status read mismatch");

  property p_maskRd;
    regRdStb && regAddr == `GIM_OFF_AIM_MASK
      |=> regRdData == $past(aim_ff);
  endproperty
  a_maskRd: assert property (p_maskRd)
    else $error("mode mask read mismatch");

  property p_lockRd;
    regRdStb && regAddr == `GIM_OFF_LOCK_STATE
      |=> regRdData == $past(lineLocked);
  endproperty
  a_lockRd: assert property (p_lockRd)
    else $error("lock status read mismatch");

  property p_owsrRd;
    regRdStb && regAddr == `GIM_OFF_OWR_STATE
      |=> regRdData == $past(owsr_ff);
  endproperty
  a_owsrRd: assert property (p_owsrRd)
    else $error("output-write status read mismatch");

  property p_owrSet;
    !guard_enable_ff && regWrStb && regAddr == `GIM_OFF_OWR_EN
      |=> (owsr_ff & $past(regWrData)) == $past(regWrData);
  endproperty
  a_owrSet: assert property (p_owrSet)
    else $error("output-write enable did not set bits");

  property p_rdIdle;
    !regRdStb
      |=> regRdData == 32'h00000000;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data not zero outside read");

  property p_guardOff;
    !guard_enable_ff
      |-> !guardBlock;
  endproperty
  a_guardOff: assert property (p_guardOff)
    else $error("write blocked while unprotected");

  property p_fallEdge;
    aim_ff[0] && !elsr_ff[0] && !pol_ff[0] && prev_ff[0] && !stable_ff[0]
      |=> irqSource[0];
  endproperty
  a_fallEdge: assert property (p_fallEdge)
    else $error("falling edge source missing");

  property p_keyZero;
    regRdStb && regAddr == `GIM_OFF_GUARD_MODE
      |=> regRdData[31:8] == 24'h000000;
  endproperty
  a_keyZero: assert property (p_keyZero)
    else $error("guard key field not read as zero");

  c_guardOn: cover property (regWrStb && regAddr == `GIM_OFF_GUARD_MODE
    ##1 guard_enable_ff);
  c_viol: cover property (guardBlock ##1 vflag_ff);
  c_fallEdge: cover property (aim_ff[0] && !elsr_ff[0] && !pol_ff[0]
    && irqSource[0]);
  c_bothEdge: cover property (!aim_ff[0] && irqSource[0]);
  c_violRead: cover property (vflag_ff && regRdStb
    && regAddr == `GIM_OFF_GUARD_VIOL);

endmodule

// ### testbench/gim_irq_mode_guard_bench.sv
`timescale 1ns/1ps
`include "gim_defines.svh"

module gim_irq_mode_guard_bench;
  logic                  clk;
  logic                  rst;
  logic                  regWrStb;
  logic                  regRdStb;
  logic                  blk;
  logic [31:0]           regAddr;
  logic [31:0]           regWrData;
  logic [31:0]           lineIn;
  logic [31:0]           lineLocked;
  logic [31:0]           m;
  logic [31:0]           st [4];
  logic [31:0]           setA [4];
  logic [31:0]           clrA [4];
  logic [31:0]           stA [4];
  gim_pkg::gim_word_type regRdData;
  gim_pkg::gim_word_type outWriteGate;
  gim_pkg::gim_word_type irqSource;
  logic                  guardEnable;
  logic                  guardBlock;
  int                    error_cnt;
  int                    samples_checked;
  int                    cyc;

  gim_irq_mode_guard i_gim_irq_mode_guard (
    .clk          (clk),
    .rst          (rst),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWrStb     (regWrStb),
    .regRdStb     (regRdStb),
    .regRdData    (regRdData),
    .lineIn       (lineIn),
    .lineLocked   (lineLocked),
    .outWriteGate (outWriteGate),
    .irqSource    (irqSource),
    .guardEnable  (guardEnable),
    .guardBlock   (guardBlock)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard well above the roughly 170 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Guard block is combinational, so it is sampled inside the strobe cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    #1 blk = guardBlock;
    @(posedge clk);
    regWrStb <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  initial begin
    rst = 1'b1;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = 32'h0;
    regWrData = 32'h0;
    lineIn = 32'h0;
    lineLocked = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(32'ha87d));
    setA = '{`GIM_OFF_OWR_EN, `GIM_OFF_AIM_EN, `GIM_OFF_LEVEL_SEL,
             `GIM_OFF_RISE_SEL};
    clrA = '{`GIM_OFF_OWR_DIS, `GIM_OFF_AIM_DIS, `GIM_OFF_EDGE_SEL,
             `GIM_OFF_FALL_SEL};
    stA = '{`GIM_OFF_OWR_STATE, `GIM_OFF_AIM_MASK, `GIM_OFF_EL_STATE,
            `GIM_OFF_POL_STATE};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    lineLocked <= $urandom;
    for (int r = 0; r < 4; r++) begin
      st[r] = 32'h0;
      rd(stA[r], 32'h0);
    end
    rd(`GIM_OFF_LOCK_STATE, lineLocked);
    rd(32'hfffff4fc, 32'h0);
    rd(`GIM_OFF_AIM_EN, 32'h0);
    for (int k = 0; k < 3; k++) begin
      for (int r = 0; r < 4; r++) begin
        m = $urandom;
        wr(setA[r], m);
        st[r] = st[r] | m;
        m = $urandom;
        wr(clrA[r], m);
        st[r] = st[r] & ~m;
        rd(stA[r], st[r]);
      end
      chk(outWriteGate, st[0]);
    end
    // Line 0 in high-level mode follows the pin level
    wr(`GIM_OFF_AIM_EN, 32'h1);
    wr(`GIM_OFF_LEVEL_SEL, 32'h1);
    wr(`GIM_OFF_RISE_SEL, 32'h1);
    lineIn <= 32'h1;
    repeat (8) @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h1);
    lineIn <= 32'h0;
    repeat (8) @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h0);
    // Falling-edge mode pulses once on the fall only
    wr(`GIM_OFF_EDGE_SEL, 32'h1);
    wr(`GIM_OFF_FALL_SEL, 32'h1);
    lineIn <= 32'h1;
    repeat (8) @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h0);
    lineIn <= 32'h0;
    repeat (5) @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h0);
    // Default mode pulses on either edge
    wr(`GIM_OFF_AIM_DIS, 32'h1);
    lineIn <= 32'h1;
    repeat (5) @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, irqSource[0]}, 32'h0);
    wr(`GIM_OFF_GUARD_MODE, {24'h123456, 8'h01});
    chk({31'h0, guardEnable}, 32'h0);
    wr(`GIM_OFF_GUARD_MODE, {`GIM_GUARD_KEY, 8'h01});
    rd(`GIM_OFF_GUARD_MODE, 32'h1);
    wr(`GIM_OFF_OWR_EN, 32'hffffffff);
    chk({31'h0, blk}, 32'h1);
    rd(`GIM_OFF_OWR_STATE, st[0]);
    rd(`GIM_OFF_GUARD_VIOL, {8'h0, 16'hf4a0, 8'h01});
    rd(`GIM_OFF_GUARD_VIOL, 32'h0);
    wr(`GIM_OFF_GUARD_MODE, 32'h0);
    chk({31'h0, guardEnable}, 32'h1);
    wr(`GIM_OFF_GUARD_MODE, {`GIM_GUARD_KEY, 8'h00});
    chk({31'h0, guardEnable}, 32'h0);
    wr(`GIM_OFF_OWR_EN, 32'hffffffff);
    chk({31'h0, blk}, 32'h0);
    rd(`GIM_OFF_OWR_STATE, 32'hffffffff);
    complete_run();
  end
endmodule
